/* File: hw/custom_logic_pkg.sv */
// shared constants, codes and carrier types of the custom logic unit
package custom_logic_pkg;

  localparam int NUM_TABLES = 4;
  localparam int NUM_PAIRS = 2;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [4:0] CTRL_OFFSET = 5'h00;
  localparam logic [4:0] SEQ0_OFFSET = 5'h01;
  localparam logic [4:0] SEQ1_OFFSET = 5'h02;
  localparam logic [4:0] IRQ_SENSE_OFFSET = 5'h05;
  localparam logic [4:0] IRQ_FLAG_OFFSET = 5'h07;
  localparam logic [4:0] TABLE_BASE_OFFSET = 5'h08;
  localparam logic [4:0] TABLE_LAST_OFFSET = 5'h17;
  localparam logic [2:0] TABLE_BASE_WORD = 3'h2;

  // sub-offsets inside one table's group of four registers
  localparam logic [1:0] TABLE_CTRLA_SUB = 2'h0;
  localparam logic [1:0] TABLE_CTRLB_SUB = 2'h1;
  localparam logic [1:0] TABLE_CTRLC_SUB = 2'h2;
  localparam logic [1:0] TABLE_TRUTH_SUB = 2'h3;

  // field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_KEEP_RUNNING_BIT = 6;
  localparam int TABLE_ENABLE_BIT = 0;
  localparam int TABLE_CLKSEL_LSB = 1;
  localparam int TABLE_FILT_LSB = 4;
  localparam int TABLE_OUTEN_BIT = 6;
  localparam int TABLE_EDGE_BIT = 7;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] NIBBLE_RESET = 4'h0;
  localparam logic [2:0] CLKSEL_LOCAL = 3'h1;

  typedef enum logic [3:0] {
    SRC_MASK = 4'h0,
    SRC_FEEDBACK = 4'h1,
    SRC_LINK = 4'h2,
    SRC_EVENT_A = 4'h3,
    SRC_EVENT_B = 4'h4,
    SRC_PIN = 4'h5,
    SRC_COMPARATOR = 4'h6,
    SRC_SERIAL = 4'h8,
    SRC_SPI = 4'h9,
    SRC_TIMER_A = 4'ha,
    SRC_TIMER_B = 4'hc
  } input_source_select_t;

  typedef enum logic [3:0] {
    SEQ_OFF = 4'h0,
    GATED_FLIPFLOP_MODE = 4'h1,
    SET_RESET_TOGGLE_FLIPFLOP_MODE = 4'h2,
    TRANSPARENT_LATCH_MODE = 4'h3,
    SET_CLEAR_LATCH_MODE = 4'h4
  } pair_sequencer_select_t;

  typedef enum logic [1:0] {
    FILT_NONE = 2'h0,
    RESAMPLE_MODE = 2'h1,
    FILT_PERSIST = 2'h2
  } output_filter_select_t;

  typedef enum logic [1:0] {
    SENSE_OFF = 2'h0,
    SENSE_RISE = 2'h1,
    SENSE_FALL = 2'h2,
    SENSE_BOTH = 2'h3
  } irq_sense_select_t;

  // peripheral outputs offered as table inputs
  typedef struct packed {
    logic comparatorOut;
    logic [2:0] serialTx;
    logic spiMosi;
    logic spiSck;
    logic [2:0] timerAWave;
    logic [2:0] timerBWave;
  } periph_in_t;

endpackage

/* File: hw/table_output_stage.sv */
// per-table resampler, persistence filter and rising-edge pulse stage
module table_output_stage (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clear,
  input wire logic tick,
  input wire logic din,
  input wire custom_logic_pkg::output_filter_select_t filterSel,
  input wire logic edgeEnable,
  output logic dout
);
  import custom_logic_pkg::*;

  logic [2:0] chain_q;
  logic persist_q;
  logic edgePrev_q;
  logic filtered;

  always_ff @(posedge clk)
  begin
    if (sys_rst || clear)
      chain_q <= 3'h0;
    else if (tick)
      chain_q <= {chain_q[1:0], din};
  end

  // persistent value passes on fourth edge
  always_ff @(posedge clk)
  begin
    if (sys_rst || clear)
      persist_q <= 1'b0;
    else if (tick && chain_q[0] == chain_q[1] && chain_q[1] == chain_q[2])
      persist_q <= chain_q[2];
  end

  always_comb
  begin
    case (filterSel)
      FILT_NONE: filtered = din;
      RESAMPLE_MODE: filtered = chain_q[1];
      FILT_PERSIST: filtered = persist_q;
      default: filtered = din;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst || clear)
      edgePrev_q <= 1'b0;
    else if (tick)
      edgePrev_q <= filtered;
  end

  assign dout = edgeEnable ? (filtered & ~edgePrev_q) : filtered;

endmodule // table_output_stage

/* File: hw/custom_logic_unit.sv */
// four-table programmable glue logic with pair sequencers and register port
//
// Overview of operation
// - Linked input takes next table's direct output; table 0 feeds table 3.
// - Feedback input takes the pair sequencer output into both tables of the pair; the code feeds the registered state seqState_q.
// - Pin input takes the dedicated pin for that table and input index.
// - Without filtering the table output is purely combinational.
// - Resample mode delays the output by two table-clock edges.
// - Filter mode passes only values held over three edges, four edges delay.
// - Filter state clears one cycle after the table is disabled.
// - Edge detector pulses on rising edges of its input.
// - Edge detector state clears one cycle after the table is disabled.
// - One sequencer per even/odd pair, mode from per-pair field.
// - Sequencer runs on the even table's selected clock.
// - Sequencer updates on rising edge; even disable clears it, reset held one cycle.
// - Gated flip-flop: data even, gate odd; captures when gate high.
// - JK: J even, K odd; hold, clear, set, toggle.
// - Transparent latch: data even, gate odd; transparent while gate high.
// - Set/clear latch: set even, clear odd; both high is forbidden.
// - Clock select 1 uses third input as clock, seen low by the table.
// - Sensed output changes set sticky flags, ORed into one request.
// - Outputs offered as level events; two raw event inputs per table.
// - Standby without keep-running forces clocked-stage outputs to zero.
// - Sequencer field: 0 off, 1 flip-flop, 2 JK, 3 latch, 4 set/clear.
// - Sense field: 0 off, 1 rising, 2 falling, 3 both.
// - Writing one to a flag clears it, zero leaves it.
//
// Added by the designer: the address map and the address-and-strobe port.
module custom_logic_unit (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [custom_logic_pkg::ADDR_W-1:0] regAddr,
  input wire logic [custom_logic_pkg::DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [custom_logic_pkg::DATA_W-1:0] regRdata,
  input wire logic [custom_logic_pkg::NUM_TABLES-1:0] routedEventInputA,
  input wire logic [custom_logic_pkg::NUM_TABLES-1:0] routedEventInputB,
  input wire logic [3*custom_logic_pkg::NUM_TABLES-1:0] tableInputPins,
  input wire custom_logic_pkg::periph_in_t periphIn,
  input wire logic sleepStandby,
  output logic [custom_logic_pkg::NUM_TABLES-1:0] tableEventOut,
  output logic [custom_logic_pkg::NUM_TABLES-1:0] tablePinOut,
  output logic [custom_logic_pkg::NUM_TABLES-1:0] tablePinOe,
  output logic irqRequest
);
  import custom_logic_pkg::*;

  logic unitEnable_q;
  logic keepRunningAsleep_q;
  logic [3:0] pairSequencerSelect_q [NUM_PAIRS];
  logic [7:0] irqSenseSelect_q;
  logic [3:0] irqFlagBits_q;
  logic [7:0] tableCtrlA_q [NUM_TABLES];
  logic [7:0] tableCtrlB_q [NUM_TABLES];
  logic [3:0] tableCtrlC_q [NUM_TABLES];
  logic [7:0] truth_q [NUM_TABLES];
  logic [DATA_W-1:0] regRdata_q;
  logic [DATA_W-1:0] readValue;
  logic [NUM_TABLES-1:0] localPrev_q;
  logic [NUM_TABLES-1:0] outPrev_q;
  logic [NUM_PAIRS-1:0] seqState_q;
  logic [NUM_PAIRS-1:0] seqHold_q;

  logic [NUM_TABLES-1:0] tableOn;
  logic [NUM_TABLES-1:0] truthOut;
  logic [NUM_TABLES-1:0] stageOut;
  logic [NUM_TABLES-1:0] tableTick;
  logic [NUM_TABLES-1:0] senseHit;
  logic [NUM_PAIRS-1:0] pairActive;
  logic [NUM_PAIRS-1:0] pairOut;
  logic periphRun;
  logic isTableAddr;
  logic [1:0] addrTable;

  // word index of a table register, relative to the first table
  function automatic logic [1:0] tableIndex(input logic [ADDR_W-1:0] addr);
    logic [2:0] word;
    word = addr[4:2] - TABLE_BASE_WORD;
    return word[1:0];
  endfunction

  // input source multiplexer for one table input
  function automatic logic pickInput(input logic [3:0] code, input logic feedback, input logic link,
                                     input logic evA, input logic evB, input logic pin, input periph_in_t pi,
                                     input int y);
    logic r;
    r = 1'b0;
    case (code)
      SRC_FEEDBACK: r = feedback;
      SRC_LINK: r = link;
      SRC_EVENT_A: r = evA;
      SRC_EVENT_B: r = evB;
      SRC_PIN: r = pin;
      SRC_COMPARATOR: r = pi.comparatorOut;
      SRC_SERIAL: r = pi.serialTx[y];
      SRC_SPI: r = (y == 2) ? pi.spiSck : pi.spiMosi;
      SRC_TIMER_A: r = pi.timerAWave[y];
      SRC_TIMER_B: r = pi.timerBWave[y];
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  assign isTableAddr = (regAddr >= TABLE_BASE_OFFSET) && (regAddr <= TABLE_LAST_OFFSET);
  assign addrTable = tableIndex(regAddr);
  // peripheral clock stops in standby unless kept running
  assign periphRun = !(sleepStandby && !keepRunningAsleep_q);

  // unit control register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      unitEnable_q <= 1'b0;
      keepRunningAsleep_q <= 1'b0;
    end
    else if (regWrite && regAddr == CTRL_OFFSET)
    begin
      unitEnable_q <= regWdata[CTRL_ENABLE_BIT];
      keepRunningAsleep_q <= regWdata[CTRL_KEEP_RUNNING_BIT];
    end
  end

  // sequencer selects, writable only while the even table is off
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pairSequencerSelect_q[0] <= NIBBLE_RESET;
      pairSequencerSelect_q[1] <= NIBBLE_RESET;
    end
    else if (regWrite)
    begin
      if (regAddr == SEQ0_OFFSET && !tableCtrlA_q[0][TABLE_ENABLE_BIT])
        pairSequencerSelect_q[0] <= regWdata[3:0];
      if (regAddr == SEQ1_OFFSET && !tableCtrlA_q[2][TABLE_ENABLE_BIT])
        pairSequencerSelect_q[1] <= regWdata[3:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irqSenseSelect_q <= REG_RESET;
    else if (regWrite && regAddr == IRQ_SENSE_OFFSET)
      irqSenseSelect_q <= regWdata;
  end

  // table configuration; only the enable bit changes while enabled
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < NUM_TABLES; i++)
      begin
        tableCtrlA_q[i] <= REG_RESET;
        tableCtrlB_q[i] <= REG_RESET;
        tableCtrlC_q[i] <= NIBBLE_RESET;
        truth_q[i] <= REG_RESET;
      end
    end
    else if (regWrite && isTableAddr)
    begin
      for (int i = 0; i < NUM_TABLES; i++)
      begin
        if (addrTable == 2'(i))
        begin
          case (regAddr[1:0])
            TABLE_CTRLA_SUB:
              if (!tableCtrlA_q[i][TABLE_ENABLE_BIT])
                tableCtrlA_q[i] <= regWdata;
              else
                tableCtrlA_q[i][TABLE_ENABLE_BIT] <= regWdata[TABLE_ENABLE_BIT];
            TABLE_CTRLB_SUB:
              if (!tableCtrlA_q[i][TABLE_ENABLE_BIT])
                tableCtrlB_q[i] <= regWdata;
            TABLE_CTRLC_SUB:
              if (!tableCtrlA_q[i][TABLE_ENABLE_BIT])
                tableCtrlC_q[i] <= regWdata[3:0];
            TABLE_TRUTH_SUB:
              if (!tableCtrlA_q[i][TABLE_ENABLE_BIT])
                truth_q[i] <= regWdata;
            default:
              tableCtrlA_q[i] <= tableCtrlA_q[i];
          endcase
        end
      end
    end
  end

  // write one clears, a new event wins
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irqFlagBits_q <= NIBBLE_RESET;
    else if (regWrite && regAddr == IRQ_FLAG_OFFSET)
      irqFlagBits_q <= (irqFlagBits_q & ~regWdata[3:0]) | senseHit;
    else
      irqFlagBits_q <= irqFlagBits_q | senseHit;
  end

  assign irqRequest = |irqFlagBits_q;

  always_comb
  begin
    readValue = REG_RESET;
    if (isTableAddr)
    begin
      case (regAddr[1:0])
        TABLE_CTRLA_SUB: readValue = tableCtrlA_q[addrTable];
        TABLE_CTRLB_SUB: readValue = tableCtrlB_q[addrTable];
        TABLE_CTRLC_SUB: readValue = {4'h0, tableCtrlC_q[addrTable]};
        TABLE_TRUTH_SUB: readValue = truth_q[addrTable];
        default: readValue = REG_RESET;
      endcase
    end
    else
    begin
      case (regAddr)
        CTRL_OFFSET: readValue = {1'b0, keepRunningAsleep_q, 5'h00, unitEnable_q};
        SEQ0_OFFSET: readValue = {4'h0, pairSequencerSelect_q[0]};
        SEQ1_OFFSET: readValue = {4'h0, pairSequencerSelect_q[1]};
        IRQ_SENSE_OFFSET: readValue = irqSenseSelect_q;
        IRQ_FLAG_OFFSET: readValue = {4'h0, irqFlagBits_q};
        default: readValue = REG_RESET;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      regRdata_q <= REG_RESET;
    else if (regRead)
      regRdata_q <= readValue;
    else
      regRdata_q <= REG_RESET;
  end

  assign regRdata = regRdata_q;

  genvar n, y, p;
  generate
    for (n = 0; n < NUM_TABLES; n++)
    begin : g_table
      logic [2:0] tin;
      logic [2:0] truthSel;
      logic [3:0] srcCode [3];
      logic clkLocal;
      logic usesClock;
      logic rawOut;

      assign tableOn[n] = unitEnable_q && tableCtrlA_q[n][TABLE_ENABLE_BIT];
      assign srcCode[0] = tableCtrlB_q[n][3:0];
      assign srcCode[1] = tableCtrlB_q[n][7:4];
      assign srcCode[2] = tableCtrlC_q[n];

      for (y = 0; y < 3; y++)
      begin : g_in
        assign tin[y] = pickInput(srcCode[y], seqState_q[n/2], truthOut[(n+1)%NUM_TABLES],
                                  routedEventInputA[n], routedEventInputB[n], tableInputPins[3*n+y], periphIn, y);
      end

      assign clkLocal = tableCtrlA_q[n][TABLE_CLKSEL_LSB +: 3] == CLKSEL_LOCAL;
      // third input seen low when used as clock
      assign truthSel = {clkLocal ? 1'b0 : tin[2], tin[1], tin[0]};
      assign truthOut[n] = tableOn[n] & truth_q[n][truthSel];

      always_ff @(posedge clk)
      begin
        if (sys_rst)
          localPrev_q[n] <= 1'b0;
        else
          localPrev_q[n] <= tin[2];
      end

      assign tableTick[n] = clkLocal ? (tin[2] & ~localPrev_q[n]) : periphRun;

      table_output_stage u_stage (
        .clk(clk),
        .sys_rst(sys_rst),
        .clear(!tableOn[n]),
        .tick(tableTick[n]),
        .din(truthOut[n]),
        .filterSel(output_filter_select_t'(tableCtrlA_q[n][TABLE_FILT_LSB +: 2])),
        .edgeEnable(tableCtrlA_q[n][TABLE_EDGE_BIT]),
        .dout(stageOut[n])
      );

      assign usesClock = (tableCtrlA_q[n][TABLE_FILT_LSB +: 2] != FILT_NONE) || tableCtrlA_q[n][TABLE_EDGE_BIT]
                         || pairActive[n/2];
      assign rawOut = (n % 2 == 0 && pairActive[n/2]) ? pairOut[n/2] : stageOut[n];
      // final output, forced low when off or when a clocked stage's clock is stopped
      assign tableEventOut[n] = (!tableOn[n] || (usesClock && !periphRun)) ? 1'b0 : rawOut;
      assign tablePinOut[n] = tableEventOut[n] & tableCtrlA_q[n][TABLE_OUTEN_BIT];
      assign tablePinOe[n] = tableOn[n] & tableCtrlA_q[n][TABLE_OUTEN_BIT];

      always_ff @(posedge clk)
      begin
        if (sys_rst)
          outPrev_q[n] <= 1'b0;
        else
          outPrev_q[n] <= tableEventOut[n];
      end

      always_comb
      begin
        case (irq_sense_select_t'(irqSenseSelect_q[2*n +: 2]))
          SENSE_RISE: senseHit[n] = tableEventOut[n] & ~outPrev_q[n];
          SENSE_FALL: senseHit[n] = ~tableEventOut[n] & outPrev_q[n];
          SENSE_BOTH: senseHit[n] = tableEventOut[n] ^ outPrev_q[n];
          default: senseHit[n] = 1'b0;
        endcase
      end
    end

    for (p = 0; p < NUM_PAIRS; p++)
    begin : g_pair
      logic evenIn;
      logic oddIn;
      logic clearSeq;
      logic [3:0] mode;

      assign mode = pairSequencerSelect_q[p];
      assign evenIn = stageOut[2*p];
      assign oddIn = stageOut[2*p+1];
      assign pairActive[p] = tableOn[2*p] && (mode >= GATED_FLIPFLOP_MODE) && (mode <= SET_CLEAR_LATCH_MODE);

      // reset held one cycle past enable
      always_ff @(posedge clk)
      begin
        if (sys_rst)
          seqHold_q[p] <= 1'b1;
        else
          seqHold_q[p] <= !tableOn[2*p];
      end

      assign clearSeq = !tableOn[2*p] || seqHold_q[p];

      // sequencer runs on even table tick
      always_ff @(posedge clk)
      begin
        if (sys_rst || clearSeq)
          seqState_q[p] <= 1'b0;
        else if (tableTick[2*p])
        begin
          case (mode)
            GATED_FLIPFLOP_MODE:
              if (oddIn)
                seqState_q[p] <= evenIn;
            SET_RESET_TOGGLE_FLIPFLOP_MODE:
              case ({evenIn, oddIn})
                2'b01: seqState_q[p] <= 1'b0;
                2'b10: seqState_q[p] <= 1'b1;
                2'b11: seqState_q[p] <= ~seqState_q[p];
                default: seqState_q[p] <= seqState_q[p];
              endcase
            TRANSPARENT_LATCH_MODE:
              if (oddIn)
                seqState_q[p] <= evenIn;
            // set wins in the forbidden case
            SET_CLEAR_LATCH_MODE:
              if (evenIn)
                seqState_q[p] <= 1'b1;
              else if (oddIn)
                seqState_q[p] <= 1'b0;
            default:
              seqState_q[p] <= 1'b0;
          endcase
        end
      end

      // latches pass through, disable clears at once
      always_comb
      begin
        if (clearSeq)
          pairOut[p] = 1'b0;
        else if (mode == TRANSPARENT_LATCH_MODE && oddIn)
          pairOut[p] = evenIn;
        else if (mode == SET_CLEAR_LATCH_MODE && evenIn)
          pairOut[p] = 1'b1;
        else if (mode == SET_CLEAR_LATCH_MODE && oddIn)
          pairOut[p] = 1'b0;
        else
          pairOut[p] = seqState_q[p];
      end
    end
  endgenerate

endmodule // custom_logic_unit

/* File: testbench/custom_logic_unit_properties.sv */
// port-level properties of the custom logic unit
module custom_logic_unit_properties
  import custom_logic_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [custom_logic_pkg::ADDR_W-1:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [custom_logic_pkg::DATA_W-1:0] regRdata,
  input wire logic [custom_logic_pkg::NUM_TABLES-1:0] tableEventOut,
  input wire logic [custom_logic_pkg::NUM_TABLES-1:0] tablePinOut,
  input wire logic [custom_logic_pkg::NUM_TABLES-1:0] tablePinOe,
  input wire logic irqRequest
);
  timeunit 1ns;
  timeprecision 100ps;
  logic flagClear;
  assign flagClear = regWrite && (regAddr == IRQ_FLAG_OFFSET);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  AST_RDATA_IDLE: assert property (!$past(regRead) |-> regRdata == 8'h00)
    else $error("read data not zero outside its answer cycle");
  AST_RDATA_HOLE: assert property ($past(regRead) && ($past(regAddr) inside {5'h03, 5'h04, 5'h06}
    || $past(regAddr) > TABLE_LAST_OFFSET) |-> regRdata == 8'h00)
    else $error("unmapped read not zero");
  AST_FLAG_UPPER: assert property ($past(regRead) && $past(regAddr) == IRQ_FLAG_OFFSET
    |-> regRdata[7:4] == 4'h0)
    else $error("flag register upper bits set");
  AST_PIN_GATED: assert property (tablePinOut == (tableEventOut & tablePinOe))
    else $error("pin output differs from gated event output");
  AST_IRQ_CAUSE: assert property ($rose(irqRequest) |-> $past(tableEventOut) != $past(tableEventOut, 2))
    else $error("request rose without an output change");
  AST_IRQ_CLEAR: assert property ($fell(irqRequest) |-> $past(flagClear) || $past(flagClear, 2))
    else $error("request fell without a flag write");
  AST_IRQ_STICKY: assert property (irqRequest && !flagClear && !$past(flagClear) |=> irqRequest)
    else $error("request dropped while flags untouched");
  AST_IRQ_FLAGS: assert property ($past(regRead) && $past(regAddr) == IRQ_FLAG_OFFSET
    && regRdata[3:0] != 4'h0 |-> ##[0:1] irqRequest)
    else $error("flags set but no request");
endmodule // custom_logic_unit_properties

bind custom_logic_unit custom_logic_unit_properties custom_logic_unit_properties_i (.clk(clk), .sys_rst(sys_rst),
  .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .tableEventOut(tableEventOut),
  .tablePinOut(tablePinOut), .tablePinOe(tablePinOe), .irqRequest(irqRequest));

/* File: testbench/far_side_model.sv */
// far-side sources: input pins, routed events and peripheral waveforms
module far_side_model
  import custom_logic_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [11:0] pinLevel,
  input wire logic [3:0] eventALevel,
  input wire logic [3:0] eventBLevel,
  output logic [11:0] tableInputPins,
  output logic [3:0] routedEventInputA,
  output logic [3:0] routedEventInputB,
  output custom_logic_pkg::periph_in_t periphIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] waveCount_q;
  assign tableInputPins = pinLevel;
  assign routedEventInputA = eventALevel;
  assign routedEventInputB = eventBLevel;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      waveCount_q <= 8'h00;
    else
      waveCount_q <= waveCount_q + 8'h01;
  end
  // free-running SPI and timer waveforms; comparator and serial levels fixed
  assign periphIn = {4'h5, waveCount_q};
endmodule // far_side_model

/* File: testbench/custom_logic_unit_test.sv */
// self-checking bench of the custom logic unit
`define CHK(act, exp) \
  begin \
    compares++; \
    if ((act) !== (exp)) \
    begin \
      miscompares++; \
      $display("MISMATCH at %0t: got %h expected %h", $time, (act), (exp)); \
    end \
  end
module custom_logic_unit_test
  import custom_logic_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk;
  logic sys_rst;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata;
  logic regWrite;
  logic regRead;
  logic [DATA_W-1:0] regRdata;
  logic [11:0] pinLevel;
  logic [3:0] eventALevel;
  logic [3:0] eventBLevel;
  logic [11:0] tableInputPins;
  logic [3:0] routedEventInputA;
  logic [3:0] routedEventInputB;
  periph_in_t periphIn;
  logic sleepStandby;
  logic [3:0] tableEventOut;
  logic [3:0] tablePinOut;
  logic [3:0] tablePinOe;
  logic irqRequest;
  int compares = 0;
  int miscompares = 0;
  int cycles = 0;
  int filtLat [4] = '{0, 2, 4, 0};
  // steps of {even, odd, expected} per sequencer code, first step in the top bits
  logic [8:0] seqSteps [5] = '{9'h142, 9'h1ca, 9'h14e, 9'h1ca, 9'h14a};

  custom_logic_unit custom_logic_unit_i (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .routedEventInputA(routedEventInputA),
    .routedEventInputB(routedEventInputB), .tableInputPins(tableInputPins), .periphIn(periphIn),
    .sleepStandby(sleepStandby), .tableEventOut(tableEventOut), .tablePinOut(tablePinOut),
    .tablePinOe(tablePinOe), .irqRequest(irqRequest));
  far_side_model far_side_model_i (.clk(clk), .sys_rst(sys_rst), .pinLevel(pinLevel), .eventALevel(eventALevel),
    .eventBLevel(eventBLevel), .tableInputPins(tableInputPins), .routedEventInputA(routedEventInputA),
    .routedEventInputB(routedEventInputB), .periphIn(periphIn));

  always #2 clk = ~clk;

  task automatic finish_test();
    if (miscompares == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 `CHK(regRdata, e)
  endtask
  task automatic pins(input logic [11:0] p);
    @(posedge clk);
    pinLevel <= p;
    #1;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic highs(input int exp);
    int hi;
    hi = 0;
    repeat (10)
    begin
      tick(1);
      if (tableEventOut[0] === 1'b1)
        hi++;
    end
    `CHK(hi, exp)
  endtask
  task automatic latency(input int exp);
    int n;
    n = 0;
    while (tableEventOut[0] !== 1'b1 && n < 10)
    begin
      tick(1);
      n++;
    end
    `CHK(n, exp)
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      finish_test();
    end
  end

  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    regAddr = '0;
    regWdata = '0;
    regWrite = 1'b0;
    regRead = 1'b0;
    pinLevel = '0;
    eventALevel = '0;
    eventBLevel = '0;
    sleepStandby = 1'b0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 32; a++)
      rd(a[4:0], 8'h00);
    wr(CTRL_OFFSET, 8'h01);
    wr(5'h09, {4'h0, SRC_PIN});
    wr(5'h0b, 8'haa);
    for (int f = 0; f < 4; f++)
    begin
      wr(5'h08, 8'h00);
      pins(12'h000);
      wr(5'h08, 8'h41 | 8'(f << 4));
      pins(12'h001);
      latency(filtLat[f]);
    end
    `CHK(tablePinOut[0], 1'b1)
    wr(5'h08, 8'h00);
    wr(5'h08, 8'h61);
    pins(12'h000);
    tick(6);
    pins(12'h001);
    tick(1);
    pins(12'h000);
    highs(0);
    wr(5'h08, 8'h00);
    wr(5'h08, 8'hd1); // resample with edge
    pins(12'h001);
    highs(1);
    pins(12'h000);
    highs(0);
    wr(5'h08, 8'h00);
    wr(5'h08, 8'h41);
    for (int s = 0; s < 4; s++)
    begin
      wr(IRQ_SENSE_OFFSET, 8'(s));
      wr(IRQ_FLAG_OFFSET, 8'h0f);
      pins(12'h001);
      tick(3);
      rd(IRQ_FLAG_OFFSET, {7'h00, s[0]});
      `CHK(irqRequest, s[0])
      wr(IRQ_FLAG_OFFSET, 8'h0e);
      rd(IRQ_FLAG_OFFSET, {7'h00, s[0]});
      wr(IRQ_FLAG_OFFSET, 8'h01);
      pins(12'h000);
      tick(3);
      rd(IRQ_FLAG_OFFSET, {7'h00, s[1]});
      wr(IRQ_FLAG_OFFSET, 8'h0f);
      tick(2);
      `CHK(irqRequest, 1'b0)
    end
    wr(5'h15, {4'h0, SRC_LINK});
    wr(5'h17, 8'haa);
    wr(5'h14, 8'h01);
    for (int v = 0; v < 2; v++)
    begin
      pins(12'(v));
      `CHK(tableEventOut[3], v[0])
    end
    wr(5'h0d, {SRC_EVENT_B, SRC_EVENT_A});
    wr(5'h0f, 8'h88);
    wr(5'h0c, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      eventALevel <= {2'b00, i[0], 1'b0};
      eventBLevel <= {2'b00, i[1], 1'b0};
      #1 `CHK(tableEventOut[1], i[0] & i[1])
    end
    for (int m = 0; m < 5; m++)
    begin
      wr(5'h08, 8'h00);
      wr(5'h0c, 8'h00);
      pins(12'h000);
      wr(SEQ0_OFFSET, 8'(m));
      wr(5'h0d, {4'h0, SRC_PIN});
      wr(5'h0f, 8'haa);
      wr(5'h0c, 8'h01);
      wr(5'h08, 8'h01);
      tick(3);
      for (int k = 2; k >= 0; k--)
      begin
        pins({8'h00, seqSteps[m][3*k+1], 2'b00, seqSteps[m][3*k+2]});
        tick(1);
        `CHK(tableEventOut[0], seqSteps[m][3*k])
      end
      wr(SEQ0_OFFSET, 8'h00);
      rd(SEQ0_OFFSET, 8'(m));
    end
    // odd table fed by the set/clear latch state
    wr(5'h0c, 8'h00);
    wr(5'h0d, {4'h0, SRC_FEEDBACK});
    wr(5'h0c, 8'h01);
    pins(12'h001);
    tick(1);
    `CHK(tableEventOut[1], 1'b1)
    pins(12'h000);
    `CHK(tableEventOut[0], 1'b0)
    tick(1);
    `CHK(tableEventOut[1], 1'b0)
    wr(5'h0c, 8'h00);
    wr(5'h0d, {4'h0, SRC_PIN});
    wr(5'h0c, 8'h01);
    wr(5'h08, 8'h00);
    wr(SEQ0_OFFSET, 8'h00);
    wr(5'h08, 8'h11);
    pins(12'h009);
    tick(3);
    @(posedge clk);
    sleepStandby <= 1'b1;
    #1 `CHK(tableEventOut[0], 1'b0)
    `CHK(tableEventOut[1], 1'b1)
    wr(CTRL_OFFSET, 8'h41);
    tick(1);
    `CHK(tableEventOut[0], 1'b1)
    @(posedge clk);
    sleepStandby <= 1'b0;
    // unit off while the clock source changes
    wr(CTRL_OFFSET, 8'h00);
    wr(5'h08, 8'h00);
    wr(5'h0a, {4'h0, SRC_PIN});
    wr(5'h0b, 8'h0a);
    wr(5'h08, 8'h13);
    pins(12'h000);
    wr(CTRL_OFFSET, 8'h01);
    pins(12'h001);
    tick(5);
    `CHK(tableEventOut[0], 1'b0)
    pins(12'h005);
    pins(12'h001);
    pins(12'h005);
    tick(2);
    `CHK(tableEventOut[0], 1'b1)
    finish_test();
  end
endmodule // custom_logic_unit_test
